// ===== ard_consts.vh
// Constants for the data-memory access and external bus steering block.
// Assumes i_clk is the oscillator clock and the core addresses its SFRs by 8-bit address.
`ifndef ARD_CONSTS_VH
`define ARD_CONSTS_VH

// Special function register addresses
`define ARD_SFR_AUX_HIGH       8'ha1
`define ARD_SFR_CHIP_CTL       8'hbf
`define ARD_SFR_CHIP_KEY       8'hf6

// Reset values
`define ARD_AUX_HIGH_RST       8'h00
`define ARD_CHIP_CTL_RST       8'h00
`define ARD_PORT2_IDLE         8'hff

// Chip control fields; bits 6:5 are not implemented and read as zero
`define ARD_CC_AUX_EN_BIT      4
`define ARD_CC_WMASK           8'h9f

// Unlock key bytes
`define ARD_KEY_FIRST          8'h87
`define ARD_KEY_SECOND         8'h59
`define ARD_KEY_LOCK           8'h00

// Address ranges
`define ARD_DIRECT_TOP         8'h7f
`define ARD_AUX_TOP            16'h03ff
`define ARD_AUX_AW             10
`define ARD_SCR_AW             8

// Bus slot timing: oscillator clocks per address latch strobe, strobe length, last phase
`define ARD_OSC_PER_ALE        6
`define ARD_ALE_PHASES         3'h2
`define ARD_PHASE_LAST         3'h5

`endif

// ===== ard_ram.v
// Single-port synchronous RAM used for the scratchpad and the auxiliary RAM.
// Assumes one access per clock; read data appears the cycle after the address.
`timescale 1ns/1ps
`default_nettype none

module ard_ram #(
   parameter AW = 8
) (
   // Clock
   input  wire          i_clk,
   // Access
   input  wire          i_we,
   input  wire [AW-1:0] i_addr,
   input  wire [7:0]    i_wdata,
   output reg  [7:0]    o_rdata
);

   reg [7:0] mem [0:(1<<AW)-1];

   // Contents are not reset, as with any on-chip data RAM
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end

endmodule

`default_nettype wire

// ===== ard_phase.v
// Free-running slot phase counter for the external bus.
// Assumes i_clk is the oscillator clock; one slot lasts ARD_OSC_PER_ALE clocks.
`timescale 1ns/1ps
`default_nettype none
`include "ard_consts.vh"

module ard_phase (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_resetn,
   // Phase
   output reg  [2:0] o_phase,
   output wire [2:0] o_phase_next
);

   assign o_phase_next = (o_phase == `ARD_PHASE_LAST) ? 3'h0 : o_phase + 3'h1;

   always @(posedge i_clk) begin
      if (!i_resetn) begin
         // Parked on the last phase so the first slot after reset is whole and ALE gives no runt pulse
         o_phase <= `ARD_PHASE_LAST;
      end else begin
         o_phase <= o_phase_next;
      end
   end

endmodule

`default_nettype wire

// ===== ard_top.v
// Data-memory access and external bus steering: scratchpad, auxiliary RAM, unlock key,
// chip control, and the multiplexed external address/data bus with its strobes.
// Assumes the core issues one request at a time and only while o_bus_busy is low.
`timescale 1ns/1ps
`default_nettype none
`include "ard_consts.vh"

// Contract
// - Scratchpad 00-7F reachable both directly and through bank pointers.
// - Scratchpad 80-FF reachable only indirectly; direct 80-FF goes elsewhere.
// - Enabled, external moves to 0-3FF use auxiliary RAM via pointer or data pointer.
// - External moves above 3FF run as external bus data cycles.
// - Low external moves reach auxiliary RAM only while chip control bit 4 set.
// - Auxiliary RAM accesses leave port 0, port 2 and strobes untouched.
// - Pointer-based external moves take high address from aux high register.
// - Address latch strobe pulses at one sixth of the oscillator rate.
// - Address latch strobe marks the low address phase on port 0.
// - Program store strobe active on external fetches, idle on internal fetches.
// - External access low forces external fetch; high keeps internal fetch off bus.
// - Port 0 carries multiplexed low address then data during external accesses.
// - Port 2 carries the upper address during external accesses.
// - Program space and data space are each 64K, kept separate.
module ard_top (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_resetn,
   // Core internal data port (scratchpad and SFRs)
   input  wire        i_mem_req,
   input  wire        i_mem_indirect,
   input  wire        i_mem_we,
   input  wire [7:0]  i_mem_addr,
   input  wire [7:0]  i_mem_wdata,
   output wire [7:0]  o_mem_rdata,
   output reg         o_mem_ack,
   output reg         o_mem_sfr_other,
   // Core external data move port
   input  wire        i_xmove_req,
   input  wire        i_xmove_use_data_pointer,
   input  wire        i_xmove_we,
   input  wire [7:0]  i_bank_pointer,
   input  wire [15:0] i_data_pointer,
   input  wire [7:0]  i_xmove_wdata,
   output wire [7:0]  o_xmove_rdata,
   output reg         o_xmove_ack,
   // Core program fetch port
   input  wire        i_fetch_req,
   input  wire [15:0] i_fetch_addr,
   output reg  [7:0]  o_fetch_data,
   output reg         o_fetch_ack,
   output wire        o_bus_busy,
   // Internal program flash
   output reg  [15:0] o_irom_addr,
   input  wire [7:0]  i_irom_data,
   // Device pins
   input  wire        i_external_access_in_n,
   input  wire [7:0]  i_port0_in,
   output reg  [7:0]  o_port0_out,
   output reg         o_port0_oe,
   output reg  [7:0]  o_port2,
   output reg         o_ale,
   output reg         o_program_store_strobe_n,
   output reg         o_read_strobe_n,
   output reg         o_write_strobe_n,
   // Status
   output wire        o_aux_ram_enabled
);

   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_RUN  = 2'h2;
   localparam ST_IROM = 2'h3;

   localparam KIND_FETCH = 2'h0;
   localparam KIND_READ  = 2'h1;
   localparam KIND_WRITE = 2'h2;

   localparam KEY_LOCKED = 2'h0;
   localparam KEY_HALF   = 2'h1;
   localparam KEY_OPEN   = 2'h2;

   // Registers
   reg  [7:0]  aux_ram_high_address;
   reg  [7:0]  chip_control;
   reg  [1:0]  key_state;
   reg  [7:0]  sfr_q;
   reg         mem_from_ram;

   // External bus sequencer
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [1:0]  bus_kind;
   reg  [15:0] bus_addr;
   reg  [7:0]  bus_wdata;
   reg  [7:0]  bus_rdata;
   reg         xm_from_aux;

   wire [2:0]  phase;
   wire [2:0]  phase_next;
   wire [7:0]  scr_q;
   wire [7:0]  aux_q;

   wire        idle     = (state == ST_IDLE);
   wire        take_xm  = idle & i_xmove_req;
   wire        take_fe  = idle & i_fetch_req & ~i_xmove_req;
   wire        aux_en   = chip_control[`ARD_CC_AUX_EN_BIT];

   // Pointer moves get the high byte from the aux high register
   wire [15:0] xm_addr  = i_xmove_use_data_pointer ? i_data_pointer : {aux_ram_high_address, i_bank_pointer};
   // Only low addresses, and only while enabled, go to the auxiliary RAM
   wire        aux_hit  = aux_en & (xm_addr <= `ARD_AUX_TOP);

   // A slot may start on the edge that takes the request, before bus_addr holds it
   wire [15:0] slot_addr  = idle ? (take_xm ? xm_addr : i_fetch_addr) : bus_addr;
   wire [7:0]  slot_wdata = idle ? i_xmove_wdata : bus_wdata;
   wire [1:0]  slot_kind  = !idle ? bus_kind : (take_xm ? (i_xmove_we ? KIND_WRITE : KIND_READ) : KIND_FETCH);

   // Indirect reaches all 256 bytes; direct only the lower half
   wire        scr_sel  = i_mem_indirect | (i_mem_addr <= `ARD_DIRECT_TOP);
   wire        sfr_wr   = i_mem_req & i_mem_we & ~scr_sel;

   assign o_bus_busy        = ~idle;
   assign o_aux_ram_enabled = aux_en;
   assign o_mem_rdata       = mem_from_ram ? scr_q : sfr_q;
   assign o_xmove_rdata     = xm_from_aux ? aux_q : bus_rdata;

   ard_ram #(
      .AW      (`ARD_SCR_AW)
   ) u_scratch (
      .i_clk   (i_clk),
      .i_we    (i_mem_req & i_mem_we & scr_sel),
      .i_addr  (i_mem_addr),
      .i_wdata (i_mem_wdata),
      .o_rdata (scr_q)
   );

   ard_ram #(
      .AW      (`ARD_AUX_AW)
   ) u_aux (
      .i_clk   (i_clk),
      .i_we    (take_xm & aux_hit & i_xmove_we),
      .i_addr  (xm_addr[`ARD_AUX_AW-1:0]),
      .i_wdata (i_xmove_wdata),
      .o_rdata (aux_q)
   );

   ard_phase u_phase (
      .i_clk        (i_clk),
      .i_resetn     (i_resetn),
      .o_phase      (phase),
      .o_phase_next (phase_next)
   );

   // Special function registers and the unlock key
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         aux_ram_high_address <= `ARD_AUX_HIGH_RST;
         chip_control         <= `ARD_CHIP_CTL_RST;
         key_state            <= KEY_LOCKED;
         sfr_q                <= 8'h00;
         mem_from_ram         <= 1'b0;
         o_mem_ack            <= 1'b0;
         o_mem_sfr_other      <= 1'b0;
      end else begin
         o_mem_ack       <= i_mem_req;
         mem_from_ram    <= scr_sel;
         o_mem_sfr_other <= i_mem_req & ~scr_sel & (i_mem_addr != `ARD_SFR_AUX_HIGH) &
                            (i_mem_addr != `ARD_SFR_CHIP_CTL) & (i_mem_addr != `ARD_SFR_CHIP_KEY);
         if (sfr_wr && i_mem_addr == `ARD_SFR_AUX_HIGH) begin
            aux_ram_high_address <= i_mem_wdata;
         end
         // A write while open is taken; the key stays open until 00 or any other byte relocks it
         if (sfr_wr && i_mem_addr == `ARD_SFR_CHIP_CTL && key_state == KEY_OPEN) begin
            chip_control <= i_mem_wdata & `ARD_CC_WMASK;
         end
         if (sfr_wr && i_mem_addr == `ARD_SFR_CHIP_KEY) begin
            if (i_mem_wdata == `ARD_KEY_FIRST) begin
               key_state <= KEY_HALF;
            end else if (i_mem_wdata == `ARD_KEY_SECOND && key_state == KEY_HALF) begin
               key_state <= KEY_OPEN;
            end else begin
               key_state <= KEY_LOCKED;
            end
         end
         // Key register is write-only and reads as zero
         case (i_mem_addr)
            `ARD_SFR_AUX_HIGH: begin
               sfr_q <= aux_ram_high_address;
            end
            `ARD_SFR_CHIP_CTL: begin
               sfr_q <= chip_control;
            end
            default: begin
               sfr_q <= 8'h00;
            end
         endcase
      end
   end

   // Sequencer next state; bus cycles start only on a slot boundary
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take_xm && !aux_hit) begin
               next_state = (phase_next == 3'h0) ? ST_RUN : ST_WAIT;
            end else if (take_fe && i_external_access_in_n) begin
               next_state = ST_IROM;
            end else if (take_fe) begin
               next_state = (phase_next == 3'h0) ? ST_RUN : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (phase_next == 3'h0) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (phase == `ARD_PHASE_LAST) begin
               next_state = ST_IDLE;
            end
         end
         ST_IROM: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Request capture, acknowledges and internal fetch path
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         state        <= ST_IDLE;
         bus_kind     <= KIND_FETCH;
         bus_addr     <= 16'h0000;
         bus_wdata    <= 8'h00;
         bus_rdata    <= 8'h00;
         xm_from_aux  <= 1'b0;
         o_xmove_ack  <= 1'b0;
         o_fetch_ack  <= 1'b0;
         o_fetch_data <= 8'h00;
         o_irom_addr  <= 16'h0000;
      end else begin
         state       <= next_state;
         o_xmove_ack <= 1'b0;
         o_fetch_ack <= 1'b0;
         if (take_xm) begin
            xm_from_aux <= aux_hit;
            bus_addr    <= xm_addr;
            bus_wdata   <= i_xmove_wdata;
            bus_kind    <= i_xmove_we ? KIND_WRITE : KIND_READ;
            // Auxiliary RAM answers next cycle without any bus activity
            o_xmove_ack <= aux_hit;
         end else if (take_fe) begin
            // Full 16-bit program address space
            bus_addr    <= i_fetch_addr;
            bus_kind    <= KIND_FETCH;
            o_irom_addr <= i_fetch_addr;
         end
         if (state == ST_IROM) begin
            o_fetch_data <= i_irom_data;
            o_fetch_ack  <= 1'b1;
         end
         if (state == ST_RUN && phase == `ARD_PHASE_LAST) begin
            if (bus_kind == KIND_FETCH) begin
               o_fetch_data <= i_port0_in;
               o_fetch_ack  <= 1'b1;
            end else begin
               bus_rdata   <= i_port0_in;
               o_xmove_ack <= 1'b1;
            end
         end
      end
   end

   // Pin drivers, registered from next state and next phase so they line up with the slot
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_ale                    <= 1'b0;
         o_port0_out              <= 8'h00;
         o_port0_oe               <= 1'b0;
         o_port2                  <= `ARD_PORT2_IDLE;
         o_program_store_strobe_n <= 1'b1;
         o_read_strobe_n          <= 1'b1;
         o_write_strobe_n         <= 1'b1;
      end else begin
         // Free running: two of every six oscillator clocks
         o_ale                    <= (phase_next < `ARD_ALE_PHASES);
         o_port0_oe               <= 1'b0;
         o_program_store_strobe_n <= 1'b1;
         o_read_strobe_n          <= 1'b1;
         o_write_strobe_n         <= 1'b1;
         if (next_state == ST_RUN) begin
            o_port2 <= slot_addr[15:8];
            if (phase_next < `ARD_ALE_PHASES) begin
               // Low address while the latch strobe is high
               o_port0_out <= slot_addr[7:0];
               o_port0_oe  <= 1'b1;
            end else begin
               // Data phase: drive write data, otherwise release for the external part
               o_port0_out              <= slot_wdata;
               o_port0_oe               <= (slot_kind == KIND_WRITE);
               o_program_store_strobe_n <= ~(slot_kind == KIND_FETCH);
               o_read_strobe_n          <= ~(slot_kind == KIND_READ);
               o_write_strobe_n         <= ~(slot_kind == KIND_WRITE);
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== ard_sva.sv
// Checker for the data-memory access and external bus steering block.
// Assumes it is bound to ard_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ard_sva (
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_resetn,
   // Core side
   input wire logic        i_mem_req,
   input wire logic        i_mem_indirect,
   input wire logic [7:0]  i_mem_addr,
   input wire logic        o_mem_sfr_other,
   input wire logic        i_xmove_req,
   input wire logic        i_xmove_use_data_pointer,
   input wire logic [15:0] i_data_pointer,
   input wire logic        o_xmove_ack,
   input wire logic        i_fetch_req,
   input wire logic        o_fetch_ack,
   input wire logic        o_bus_busy,
   // Pins
   input wire logic        i_external_access_in_n,
   input wire logic        o_port0_oe,
   input wire logic [7:0]  o_port2,
   input wire logic        o_ale,
   input wire logic        o_program_store_strobe_n,
   input wire logic        o_read_strobe_n,
   input wire logic        o_write_strobe_n,
   input wire logic        o_aux_ram_enabled
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire xgo = i_xmove_req && !o_bus_busy;
   wire lo  = i_xmove_use_data_pointer && i_data_pointer <= 16'h03ff;
   property p_ale; $rose(o_ale) |=> o_ale ##1 !o_ale [*4] ##1 o_ale; endproperty
   a_ale: assert property (p_ale) else $error("ale period");
   property p_dir;
      i_mem_req && !i_mem_indirect && i_mem_addr > 8'h7f && !(i_mem_addr inside {8'ha1, 8'hbf, 8'hf6})
      |=> o_mem_sfr_other;
   endproperty
   a_dir: assert property (p_dir) else $error("direct high");
   property p_aux; xgo && o_aux_ram_enabled && lo |=> o_xmove_ack; endproperty
   a_aux: assert property (p_aux) else $error("aux ack");
   property p_quiet;
      xgo && o_aux_ram_enabled && lo |=> $stable(o_port2) && !o_port0_oe && o_read_strobe_n && o_write_strobe_n;
   endproperty
   a_quiet: assert property (p_quiet) else $error("aux pins");
   property p_ext; xgo && i_xmove_use_data_pointer && i_data_pointer > 16'h03ff |=> !o_xmove_ack [*6] ##[0:6] o_xmove_ack; endproperty
   a_ext: assert property (p_ext) else $error("ext move");
   property p_off; xgo && !o_aux_ram_enabled |=> !o_xmove_ack; endproperty
   a_off: assert property (p_off) else $error("aux off");
   property p_ifetch;
      i_fetch_req && !o_bus_busy && !i_xmove_req && i_external_access_in_n
      |=> o_program_store_strobe_n ##1 (o_program_store_strobe_n && o_fetch_ack);
   endproperty
   a_ifetch: assert property (p_ifetch) else $error("int fetch");
   property p_adr; o_ale |-> o_read_strobe_n && o_write_strobe_n && o_program_store_strobe_n; endproperty
   a_adr: assert property (p_adr) else $error("addr phase");
   property p_hi; !o_read_strobe_n |-> $stable(o_port2); endproperty
   a_hi: assert property (p_hi) else $error("port2");
   property p_rst; disable iff (1'b0) !i_resetn |=> !o_aux_ram_enabled && o_port2 == 8'hff; endproperty
   a_rst: assert property (p_rst) else $error("reset");
endmodule
bind ard_top ard_sva chk_u (.i_clk, .i_resetn, .i_mem_req, .i_mem_indirect, .i_mem_addr, .o_mem_sfr_other,
   .i_xmove_req, .i_xmove_use_data_pointer, .i_data_pointer, .o_xmove_ack, .i_fetch_req, .o_fetch_ack, .o_bus_busy,
   .i_external_access_in_n, .o_port0_oe, .o_port2, .o_ale, .o_program_store_strobe_n, .o_read_strobe_n,
   .o_write_strobe_n, .o_aux_ram_enabled);
`default_nettype wire

// ===== ard_ext_mem.sv
// External data SRAM, program ROM and address latch on the multiplexed bus.
// Assumes active-low strobes; port 0 has a pull-up, so a released bus reads ff.
`timescale 1ns/1ps
`default_nettype none
module ard_ext_mem (
   // Clock
   input  wire logic       i_clk,
   // Device bus pins
   input  wire logic       i_ale,
   input  wire logic [7:0] i_p0,
   input  wire logic       i_oe,
   input  wire logic [7:0] i_p2,
   input  wire logic       i_pss_n,
   input  wire logic       i_rd_n,
   input  wire logic       i_wr_n,
   // Port 0 wire level
   output wire logic [7:0] o_p0
);
   logic [7:0]  lat;
   logic [7:0]  dm [0:65535];
   wire  [15:0] a = {i_p2, lat};
   initial for (int k = 0; k < 65536; k++) dm[k] = 8'h00;
   assign o_p0 = i_oe ? i_p0 : !i_rd_n ? dm[a] : !i_pss_n ? a[7:0] ^ 8'h3c : 8'hff;
   // Taken on the clock while the strobe is high, so the address and the falling strobe never race
   always @(posedge i_clk) if (i_ale) lat <= o_p0;
   always @(posedge i_clk) if (!i_wr_n) dm[a] <= o_p0;
endmodule
`default_nettype wire

// ===== ard_tb.sv
// Testbench for ard_top: core-side access tasks against an external memory model.
// Assumes a 100 MHz clock and internal flash that returns the inverted low address byte.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic i_clk = '0, i_resetn = '0, i_mem_req = '0, i_mem_indirect = '0, i_mem_we = '0;
   logic i_xmove_req = '0, i_xmove_use_data_pointer = '0, i_xmove_we = '0, i_fetch_req = '0;
   logic i_external_access_in_n = 1'h1;
   logic [7:0]  i_mem_addr = '0, i_mem_wdata = '0, i_bank_pointer = '0, i_xmove_wdata = '0;
   logic [15:0] i_data_pointer = '0, i_fetch_addr = '0, o_irom_addr;
   logic [7:0]  o_mem_rdata, o_xmove_rdata, o_fetch_data, i_irom_data, i_port0_in, o_port0_out, o_port2;
   logic o_mem_ack, o_mem_sfr_other, o_xmove_ack, o_fetch_ack, o_bus_busy, o_port0_oe, o_ale;
   logic o_program_store_strobe_n, o_read_strobe_n, o_write_strobe_n, o_aux_ram_enabled;
   int failures = 0, samples_checked = 0;
   assign i_irom_data = ~o_irom_addr[7:0];
   ard_top dut_u (.i_clk, .i_resetn, .i_mem_req, .i_mem_indirect, .i_mem_we, .i_mem_addr, .i_mem_wdata,
      .o_mem_rdata, .o_mem_ack, .o_mem_sfr_other, .i_xmove_req, .i_xmove_use_data_pointer, .i_xmove_we,
      .i_bank_pointer, .i_data_pointer, .i_xmove_wdata, .o_xmove_rdata, .o_xmove_ack, .i_fetch_req,
      .i_fetch_addr, .o_fetch_data, .o_fetch_ack, .o_bus_busy, .o_irom_addr, .i_irom_data,
      .i_external_access_in_n, .i_port0_in, .o_port0_out, .o_port0_oe, .o_port2, .o_ale,
      .o_program_store_strobe_n, .o_read_strobe_n, .o_write_strobe_n, .o_aux_ram_enabled);
   ard_ext_mem ext_u (.i_clk, .i_ale(o_ale), .i_p0(o_port0_out), .i_oe(o_port0_oe), .i_p2(o_port2),
      .i_pss_n(o_program_store_strobe_n), .i_rd_n(o_read_strobe_n), .i_wr_n(o_write_strobe_n),
      .o_p0(i_port0_in));
   initial forever #5 i_clk = ~i_clk;
   task test_done;
      if (failures == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask
   // The answer is registered on the same edge that takes the request and is read 1 ns later
   task mem(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      {i_mem_req, i_mem_we, i_mem_indirect, i_mem_addr, i_mem_wdata} <= {1'h1, w, ind, a, d};
      @(posedge i_clk);
      i_mem_req <= 1'h0;
      #1;
   endtask
   task xm(input logic w, input logic dp, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      {i_xmove_req, i_xmove_we, i_xmove_use_data_pointer, i_data_pointer, i_bank_pointer, i_xmove_wdata}
         <= {1'h1, w, dp, a, a[7:0], d};
      @(posedge i_clk);
      i_xmove_req <= 1'h0;
      #1;
      while (o_xmove_ack !== 1'h1 && n < 20) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk("xmove_ack", o_xmove_ack, 16'h1);
   endtask
   task fch(input logic [15:0] a, input logic ea);
      int n;
      n = 0;
      @(posedge i_clk);
      {i_fetch_req, i_fetch_addr, i_external_access_in_n} <= {1'h1, a, ea};
      @(posedge i_clk);
      i_fetch_req <= 1'h0;
      #1;
      while (o_fetch_ack !== 1'h1 && n < 20) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk("fetch_ack", o_fetch_ack, 16'h1);
   endtask
   task unlock;
      mem(1'h1, 1'h0, 8'hf6, 8'h87);
      mem(1'h1, 1'h0, 8'hf6, 8'h59);
   endtask
   initial begin
      #200000;
      failures++;
      test_done;
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_resetn <= 1'h1;
      mem(1'h0, 1'h0, 8'hbf, 8'h00);
      chk("chip_control", o_mem_rdata, 16'h0);
      mem(1'h0, 1'h0, 8'ha1, 8'h00);
      chk("aux_ram_high_address", o_mem_rdata, 16'h0);
      mem(1'h1, 1'h0, 8'h7f, 8'h11);
      mem(1'h0, 1'h1, 8'h7f, 8'h00);
      chk("scratch_7f", o_mem_rdata, 16'h11);
      chk("mem_ack", o_mem_ack, 16'h1);
      mem(1'h1, 1'h1, 8'h80, 8'h22);
      mem(1'h0, 1'h1, 8'h80, 8'h00);
      chk("scratch_80", o_mem_rdata, 16'h22);
      mem(1'h0, 1'h0, 8'h80, 8'h00);
      chk("direct_80", o_mem_sfr_other, 16'h1);
      mem(1'h1, 1'h0, 8'hbf, 8'h10);
      chk("locked", o_aux_ram_enabled, 16'h0);
      unlock;
      mem(1'h1, 1'h0, 8'hbf, 8'h10);
      mem(1'h1, 1'h0, 8'hf6, 8'h00);
      chk("aux_enabled", o_aux_ram_enabled, 16'h1);
      mem(1'h1, 1'h0, 8'ha1, 8'h01);
      xm(1'h1, 1'h0, 16'h0123, 8'h55);
      xm(1'h0, 1'h1, 16'h0123, 8'h00);
      chk("aux_read", o_xmove_rdata, 16'h55);
      chk("sram_untouched", ext_u.dm[16'h0123], 16'h0);
      xm(1'h1, 1'h1, 16'h7fff, 8'h78);
      chk("sram_write", ext_u.dm[16'h7fff], 16'h78);
      xm(1'h0, 1'h1, 16'h7fff, 8'h00);
      chk("sram_read", o_xmove_rdata, 16'h78);
      chk("port2", o_port2, 16'h7f);
      unlock;
      mem(1'h1, 1'h0, 8'hbf, 8'h00);
      mem(1'h1, 1'h0, 8'hf6, 8'h00);
      xm(1'h1, 1'h0, 16'h0123, 8'haa);
      chk("low_goes_out", ext_u.dm[16'h0123], 16'haa);
      fch(16'h1234, 1'h1);
      chk("int_fetch", o_fetch_data, 16'hcb);
      fch(16'h2345, 1'h0);
      chk("ext_fetch", o_fetch_data, 16'h79);
      test_done;
   end
endmodule
`default_nettype wire
